// [rrm_map.vh]
`ifndef RRM_MAP_VH
`define RRM_MAP_VH
// register byte offsets
`define RRM_OFS_CTRL 8'h00
`define RRM_OFS_RISE 8'h04
`define RRM_OFS_FALL 8'h08
`define RRM_OFS_STOP 8'h0C
`define RRM_OFS_ROUND 8'h10
`define RRM_OFS_UPDN 8'h14
`define RRM_OFS_SEL 8'h18
`define RRM_OFS_DIFN 8'h1C
`define RRM_OFS_EXTREF 8'h20
`define RRM_OFS_STAT 8'h24
`define RRM_OFS_FLAGS 8'h28
// control fields
`define RRM_CTRL_RUN 0
`define RRM_CTRL_KPUP 1
`define RRM_CTRL_KPDN 2
`define RRM_CTRL_POL_LO 4
`define RRM_CTRL_MASK 32'h0000_0037
`define RRM_SEL_MASK 32'h001F_FFFF
`define RRM_DIFN_MASK 32'h3FFF_FFFF
`define RRM_LO16_MASK 32'h0000_FFFF
// reset values
`define RRM_RST_CTRL 32'h0000_0000
`define RRM_RST_TIME 32'h2710_2710
`define RRM_RST_ROUND 32'h0000_0000
`define RRM_RST_UPDN 32'h0000_2710
`define RRM_RST_SEL 32'h0000_0000
`define RRM_RST_DIFN 32'h0000_0000
// full scale reference, 100 percent, and velocity scale
`define RRM_FS 16'h2710
`define RRM_VFULL 9'h100
`define RRM_VMIN 9'h010
// function codes of configurable digital inputs
`define RRM_FN_UP 5'h0E
`define RRM_FN_DN 5'h0F
`define RRM_FN_ZERO 5'h10
// selector codes
`define RRM_REF_MPOT 3'h5
`define RRM_SRC_TERM 3'h1
`define RRM_SRC_SERIAL 3'h2
`define RRM_SRC_FBUS 3'h3
`define RRM_SRC_KEYPAD 3'h4
// polarity modes and bus response codes
`define RRM_POL_FULL 2'h0
`define RRM_POL_POS 2'h1
`define RRM_POL_NEG 2'h2
`define RRM_RESP_OKAY 2'h0
`define RRM_RESP_SLVERR 2'h2
`endif

// [rrm_ramp.v]
// Functional notes
// - while running, ramp with separate rise and fall times per reference sign.
// - optional start rounding and separate optional end rounding of each transient.
// - run withdrawn: ramp to zero with positive or negative stop-ramp time.
// - no start or end rounding on stop-ramp transients.
// - rounded transient lasts ramp time plus half of each rounding time.
// - motor-pot reference rises on up, falls on down, from inputs or keypad.
// - motor-pot used only when some reference selector picks it; indicator then lit.
// - up and down accepted from at most three of four sources, by selectors.
// - digital input function code 14 is up, code 15 is down.
// - up and down together cancel; motor-pot reference unchanged.
// - several equal commands from different sources act as one.
// - active up or down changes motor-pot reference at its own ramp rate.
// - motor-pot ramp in series with main ramp; the slower one wins.
// - polarity setting gives full signed range or one sign only.
// - retention restores last motor-pot value at power-on, else zero.
// - zero input sets motor-pot reference to zero at once, no ramp.
// - zero beats a simultaneous up or down.
`include "rrm_map.vh"
`timescale 1ns/100ps
`default_nettype none
module rrm_ramp
(
	// clock, reset, enable, control tick
	input wire clk_in,
	input wire rst_in,
	input wire ce_in,
	input wire tick_in,
	// terminal inputs (pins) and command sources on this clock
	input wire [5:0] di_in,
	input wire serial_up_in,
	input wire serial_dn_in,
	input wire fbus_up_in,
	input wire fbus_dn_in,
	// stored parameters for retention
	input wire updown_retain_enable_in,
	input wire signed [15:0] nv_ref_in,
	// outputs
	output reg signed [15:0] ramp_ref_out,
	output reg signed [15:0] motor_pot_ref_out,
	output reg local_reference_indicator_out,
	// axi4-lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	reg [31:0] ctrl, rise, fall, stop_t, round_t, updn, sel, difn, extref;
	reg [7:0] awaddr;
	reg [31:0] wdata;
	reg [3:0] wstrb;
	reg [5:0] di_s1, di_s2;
	reg loaded;
	reg [16:0] macc;
	reg [17:0] pacc;
	reg [15:0] racc;
	reg [8:0] vel;
	reg last_up;
	// decoded commands
	reg term_up, term_dn, term_zero, cmd_up, cmd_dn, mp_used;
	reg [2:0] src;
	reg [4:0] code;
	integer i;
	wire run = ctrl[`RRM_CTRL_RUN];
	wire [1:0] pol = ctrl[`RRM_CTRL_POL_LO+1:`RRM_CTRL_POL_LO];
	wire signed [15:0] fs_s = `RRM_FS;
	wire signed [15:0] mp_max = (pol == `RRM_POL_NEG) ? 16'h0000 : fs_s;
	wire signed [15:0] mp_min = (pol == `RRM_POL_POS) ? 16'h0000 : -fs_s;

	function [31:0] rrm_merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0] strb;
		integer b;
		begin
			rrm_merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (strb[b])
					rrm_merge[8*b +: 8] = data[8*b +: 8];
		end
	endfunction

	// commands from the selected sources; equal commands simply OR together
	always @*
	begin
		term_up = 1'b0;
		term_dn = 1'b0;
		term_zero = 1'b0;
		cmd_up = 1'b0;
		cmd_dn = 1'b0;
		mp_used = 1'b0;
		src = 3'h0;
		code = 5'h00;
		for (i = 0; i < 6; i = i + 1)
		begin
			code = difn[5*i +: 5];
			term_up = term_up | (di_s2[i] & (code == `RRM_FN_UP));
			term_dn = term_dn | (di_s2[i] & (code == `RRM_FN_DN));
			term_zero = term_zero | (di_s2[i] & (code == `RRM_FN_ZERO));
		end
		for (i = 0; i < 3; i = i + 1)
		begin
			src = sel[12 + 3*i +: 3];
			case (src)
				`RRM_SRC_TERM:
				begin
					cmd_up = cmd_up | term_up;
					cmd_dn = cmd_dn | term_dn;
				end
				`RRM_SRC_SERIAL:
				begin
					cmd_up = cmd_up | serial_up_in;
					cmd_dn = cmd_dn | serial_dn_in;
				end
				`RRM_SRC_FBUS:
				begin
					cmd_up = cmd_up | fbus_up_in;
					cmd_dn = cmd_dn | fbus_dn_in;
				end
				`RRM_SRC_KEYPAD:
				begin
					cmd_up = cmd_up | ctrl[`RRM_CTRL_KPUP];
					cmd_dn = cmd_dn | ctrl[`RRM_CTRL_KPDN];
				end
				default:
				begin
					cmd_up = cmd_up;
					cmd_dn = cmd_dn;
				end
			endcase
		end
		for (i = 0; i < 4; i = i + 1)
			mp_used = mp_used | (sel[3*i +: 3] == `RRM_REF_MPOT);
	end

	// main ramp: target, ramp time and rounding selection
	wire signed [15:0] tgt = !run ? 16'h0000 : (mp_used ? motor_pot_ref_out : extref[15:0]);
	wire signed [16:0] diff = {tgt[15], tgt} - {ramp_ref_out[15], ramp_ref_out};
	wire dir_up = !diff[16];
	wire [16:0] rem = diff[16] ? -diff : diff;
	wire ref_pos = (ramp_ref_out > 16'sh0000) || ((ramp_ref_out == 16'sh0000) && dir_up);
	wire away = (dir_up == ref_pos);
	wire [15:0] t_run = ref_pos ? (away ? rise[15:0] : fall[15:0]) : (away ? rise[31:16] : fall[31:16]);
	wire [15:0] t_stop = ref_pos ? stop_t[15:0] : stop_t[31:16];
	wire [15:0] t_sel = run ? t_run : t_stop;
	wire [15:0] ts = run ? round_t[15:0] : 16'h0000;
	wire [15:0] te = run ? round_t[31:16] : 16'h0000;
	// end rounding begins once the remaining distance fits a linear slow-down over te
	wire [33:0] brake_l = rem * {t_sel, 1'b0};
	// both factors widened first so the product keeps all 32 bits
	wire [33:0] brake_r = {18'h00000, `RRM_FS} * {18'h00000, te};
	wire decel = (te != 16'h0000) && (brake_l <= brake_r) && (vel != 9'h000);
	wire [8:0] vel_eff = (!decel && (ts == 16'h0000)) ? `RRM_VFULL : vel;
	wire [24:0] vstep = `RRM_FS * vel_eff;
	wire [17:0] pacc_sum = pacc + {1'b0, vstep[24:8]};
	wire [15:0] rdiv = decel ? te : ts;
	wire [15:0] racc_sum = racc + {7'h00, `RRM_VFULL};
	wire [16:0] macc_sum = macc + {1'b0, `RRM_FS};
	wire mp_step = (updn[15:0] == 16'h0000) || (macc_sum >= {1'b0, updn[15:0]});
	wire adv = ce_in & tick_in;

	// motor potentiometer reference
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			motor_pot_ref_out <= 16'sh0000;
			macc <= 17'h00000;
			loaded <= 1'b0;
		end
		else if (ce_in)
		begin
			if (!loaded)
			begin
				loaded <= 1'b1;
				motor_pot_ref_out <= updown_retain_enable_in ? nv_ref_in : 16'sh0000;
			end
			else if (term_zero)
			begin
				motor_pot_ref_out <= 16'sh0000;
				macc <= 17'h00000;
			end
			else if (motor_pot_ref_out > mp_max)
				motor_pot_ref_out <= mp_max;
			else if (motor_pot_ref_out < mp_min)
				motor_pot_ref_out <= mp_min;
			else if (adv && (cmd_up != cmd_dn))
			begin
				macc <= mp_step ? 17'h00000 : macc_sum;
				if (mp_step && cmd_up && (motor_pot_ref_out < mp_max))
					motor_pot_ref_out <= motor_pot_ref_out + 16'sh0001;
				else if (mp_step && cmd_dn && (motor_pot_ref_out > mp_min))
					motor_pot_ref_out <= motor_pot_ref_out - 16'sh0001;
			end
		end
	end

	// main ramp; while running with the motor-pot selected, its value is the target, so the slower ramp governs
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ramp_ref_out <= 16'sh0000;
			pacc <= 18'h00000;
			racc <= 16'h0000;
			vel <= 9'h000;
			last_up <= 1'b1;
			local_reference_indicator_out <= 1'b0;
		end
		else if (ce_in)
		begin
			local_reference_indicator_out <= mp_used;
			if (adv)
			begin
				if ((diff == 17'h00000) || (dir_up != last_up))
				begin
					// settled or reversing: next transient restarts its rounding
					pacc <= 18'h00000;
					racc <= 16'h0000;
					vel <= 9'h000;
					last_up <= dir_up;
				end
				else if (t_sel == 16'h0000)
					ramp_ref_out <= tgt;
				else
				begin
					// one step per tick at most, so times under full scale ticks saturate
					if (pacc_sum >= {2'b00, t_sel})
					begin
						pacc <= (pacc_sum - {2'b00, t_sel} >= {2'b00, t_sel}) ? 18'h00000 :
							pacc_sum - {2'b00, t_sel};
						ramp_ref_out <= dir_up ? ramp_ref_out + 16'sh0001 :
							ramp_ref_out - 16'sh0001;
					end
					else
						pacc <= pacc_sum;
					if (decel || (vel_eff < `RRM_VFULL))
					begin
						// velocity changes by one unit each rdiv/256 ticks
						if ((racc_sum >= rdiv) || (rdiv < {7'h00, `RRM_VFULL}))
						begin
							racc <= 16'h0000;
							if (decel && (vel > `RRM_VMIN))
								vel <= vel - 9'h001;
							else if (!decel)
								vel <= vel + 9'h001;
						end
						else
							racc <= racc_sum;
					end
					else
						vel <= vel_eff;
				end
			end
		end
	end

	// axi4-lite write path
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RRM_RESP_OKAY;
			awaddr <= 8'h00;
			wdata <= 32'h0000_0000;
			wstrb <= 4'h0;
			ctrl <= `RRM_RST_CTRL;
			rise <= `RRM_RST_TIME;
			fall <= `RRM_RST_TIME;
			stop_t <= `RRM_RST_TIME;
			round_t <= `RRM_RST_ROUND;
			updn <= `RRM_RST_UPDN;
			sel <= `RRM_RST_SEL;
			difn <= `RRM_RST_DIFN;
			extref <= 32'h0000_0000;
			di_s1 <= 6'h00;
			di_s2 <= 6'h00;
		end
		else if (ce_in)
		begin
			di_s1 <= di_in;
			di_s2 <= di_s1;
			if (!loaded)
			begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_awready && s_axi_awvalid)
			begin
				s_axi_awready <= 1'b0;
				awaddr <= s_axi_awaddr;
			end
			if (s_axi_wready && s_axi_wvalid)
			begin
				s_axi_wready <= 1'b0;
				wdata <= s_axi_wdata;
				wstrb <= s_axi_wstrb;
			end
			if (loaded && !s_axi_awready && !s_axi_wready && !s_axi_bvalid)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RRM_RESP_OKAY;
				case (awaddr)
					`RRM_OFS_CTRL: ctrl <= rrm_merge(ctrl, wdata, wstrb) & `RRM_CTRL_MASK;
					`RRM_OFS_RISE: rise <= rrm_merge(rise, wdata, wstrb);
					`RRM_OFS_FALL: fall <= rrm_merge(fall, wdata, wstrb);
					`RRM_OFS_STOP: stop_t <= rrm_merge(stop_t, wdata, wstrb);
					`RRM_OFS_ROUND: round_t <= rrm_merge(round_t, wdata, wstrb);
					`RRM_OFS_UPDN: updn <= rrm_merge(updn, wdata, wstrb) & `RRM_LO16_MASK;
					`RRM_OFS_SEL: sel <= rrm_merge(sel, wdata, wstrb) & `RRM_SEL_MASK;
					`RRM_OFS_DIFN: difn <= rrm_merge(difn, wdata, wstrb) & `RRM_DIFN_MASK;
					`RRM_OFS_EXTREF: extref <= rrm_merge(extref, wdata, wstrb) & `RRM_LO16_MASK;
					`RRM_OFS_STAT, `RRM_OFS_FLAGS: s_axi_bresp <= `RRM_RESP_OKAY;
					default: s_axi_bresp <= `RRM_RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// axi4-lite read path
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RRM_RESP_OKAY;
		end
		else if (ce_in)
		begin
			if (!loaded)
				s_axi_arready <= 1'b1;
			if (s_axi_arready && s_axi_arvalid)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RRM_RESP_OKAY;
				case (s_axi_araddr)
					`RRM_OFS_CTRL: s_axi_rdata <= ctrl;
					`RRM_OFS_RISE: s_axi_rdata <= rise;
					`RRM_OFS_FALL: s_axi_rdata <= fall;
					`RRM_OFS_STOP: s_axi_rdata <= stop_t;
					`RRM_OFS_ROUND: s_axi_rdata <= round_t;
					`RRM_OFS_UPDN: s_axi_rdata <= updn;
					`RRM_OFS_SEL: s_axi_rdata <= sel;
					`RRM_OFS_DIFN: s_axi_rdata <= difn;
					`RRM_OFS_EXTREF: s_axi_rdata <= extref;
					`RRM_OFS_STAT: s_axi_rdata <= {motor_pot_ref_out, ramp_ref_out};
					`RRM_OFS_FLAGS: s_axi_rdata <= {28'h0000000, term_zero, cmd_dn, cmd_up, mp_used};
					default:
					begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `RRM_RESP_SLVERR;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // rrm_ramp
`default_nettype wire

// [rrm_ramp_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module rrm_ramp_properties
(
	// clock and tick
	input wire clk_in,
	input wire rst_in,
	input wire ce_in,
	input wire tick_in,
	// references
	input wire signed [15:0] ramp_ref_out,
	input wire signed [15:0] motor_pot_ref_out,
	// bus
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp
);
	// the retained value loads in one jump after reset, so step checks wait two edges
	logic [1:0] seen;
	wire step = ce_in && tick_in;
	always @(posedge clk_in or posedge rst_in)
		if (rst_in)
			seen <= 2'h0;
		else if (ce_in)
			seen <= {seen[0], 1'h1};
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	AST_MP_STEP: assert property (seen[1] && $changed(motor_pot_ref_out)
		&& motor_pot_ref_out != 16'sh0000 |-> $past(step) && (motor_pot_ref_out
		- $past(motor_pot_ref_out) == 1 || $past(motor_pot_ref_out) - motor_pot_ref_out == 1))
		else $error("motor pot jumped");
	AST_RAMP_TICK: assert property ($changed(ramp_ref_out) |-> $past(step))
		else $error("ramp moved off tick");
	AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready && ce_in |-> ##2 s_axi_bvalid) else $error("no write response");
	AST_CE_HOLD: assert property (!ce_in |=> $stable(motor_pot_ref_out)
		&& $stable(ramp_ref_out)) else $error("state moved with enable low");
	AST_B_BLOCKS: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken early");
	AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready && ce_in
		|=> !s_axi_bvalid && s_axi_awready) else $error("write response stuck");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready && ce_in
		|=> s_axi_rvalid && !s_axi_arready) else $error("no read data");
	AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready && ce_in
		|=> !s_axi_rvalid && s_axi_arready) else $error("read data stuck");
	AST_R_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
		|-> s_axi_rdata == 32'h0000_0000) else $error("error read not zero");
endmodule // rrm_ramp_properties
bind rrm_ramp rrm_ramp_properties u_props (.clk_in, .rst_in, .ce_in, .tick_in, .ramp_ref_out,
	.motor_pot_ref_out, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .s_axi_rresp);
`default_nettype wire

// [rrm_terminal.sv]
`timescale 1ns/100ps
`default_nettype none
module rrm_terminal
(
	// clock and operator contacts
	input wire clk_in,
	input wire up_in,
	input wire dn_in,
	input wire zero_in,
	// pins 0..2 match the function codes the bench programs
	output logic [5:0] di_out
);
	always @(posedge clk_in)
		di_out <= {3'h0, zero_in, dn_in, up_in};
endmodule // rrm_terminal
`default_nettype wire

// [rrm_ramp_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module rrm_ramp_bench;
	logic clk_in = 1'h0, rst_in = 1'h1, ce_in = 1'h1, tick_in = 1'h0;
	logic up = 1'h0, dn = 1'h0, zero = 1'h0, keep = 1'h0;
	logic s_up = 1'h0, s_dn = 1'h0, f_up = 1'h0, f_dn = 1'h0;
	logic signed [15:0] nv = 16'sh0000;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0000_0000;
	logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
	wire awr, wrd, bv, arr, rv, led;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [5:0] di;
	wire signed [15:0] ramp, mp;
	int failures = 0, check_count = 0;
	rrm_ramp DUT (.clk_in, .rst_in, .ce_in, .tick_in, .di_in(di), .serial_up_in(s_up),
		.serial_dn_in(s_dn), .fbus_up_in(f_up), .fbus_dn_in(f_dn),
		.updown_retain_enable_in(keep), .nv_ref_in(nv), .ramp_ref_out(ramp),
		.motor_pot_ref_out(mp), .local_reference_indicator_out(led), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
	rrm_terminal u_term (.clk_in, .up_in(up), .dn_in(dn), .zero_in(zero), .di_out(di));
	task automatic chk(input logic [31:0] g, e);
		check_count++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic end_of_test();
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic lim(input int n);
		if (n > 40)
		begin
			failures++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
		int n;
		@(posedge clk_in);
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		br <= 1'h1;
		for (n = 0; n <= 40; n++)
		begin
			@(posedge clk_in);
			if (awr)
				awv <= 1'h0;
			if (wrd)
				wv <= 1'h0;
			if (bv)
				break;
		end
		lim(n);
		br <= 1'h0;
		chk(bresp, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
		int n;
		@(posedge clk_in);
		ara <= a;
		arv <= 1'h1;
		rr <= 1'h1;
		for (n = 0; n <= 40; n++)
		begin
			@(posedge clk_in);
			if (arr)
				arv <= 1'h0;
			if (rv)
				break;
		end
		lim(n);
		rr <= 1'h0;
		chk(rdata, d);
		chk(rresp, e);
	endtask
	// skip the synchroniser delay, then count over exactly ten ticks
	task automatic slope(input logic r, input logic [15:0] e);
		logic [15:0] a;
		cyc(10);
		a = r ? ramp : mp;
		cyc(20);
		chk(16'((r ? ramp : mp) - a), e);
	endtask
	task automatic t_regs();
		chk(led, 1'h0);
		rd(8'h04, 32'h2710_2710);
		rd(8'h14, 32'h0000_2710);
		wr(8'h2C, 32'h0000_0001, 2'h2);
		rd(8'h2C, 32'h0000_0000, 2'h2);
	endtask
	task automatic t_mpot();
		wr(8'h18, 32'h0000_1005);
		wr(8'h1C, 32'h0000_41EE);
		wr(8'h14, 32'h0000_0000);
		chk(led, 1'h1);
		up <= 1'h1;
		slope(1'h0, 16'h000A);
		dn <= 1'h1;
		slope(1'h0, 16'h0000);
		up <= 1'h0;
		slope(1'h0, 16'hFFF6);
		dn <= 1'h0;
		wr(8'h00, 32'h0000_0002);
		slope(1'h0, 16'h0000);
		wr(8'h18, 32'h0002_1005);
		slope(1'h0, 16'h000A);
		up <= 1'h1;
		slope(1'h0, 16'h000A);
		zero <= 1'h1;
		slope(1'h0, 16'h0000);
		chk(mp, 16'h0000);
		zero <= 1'h0;
		up <= 1'h0;
		wr(8'h00, 32'h0000_0000);
	endtask
	task automatic t_src();
		wr(8'h18, 32'h0000_2005);
		s_up <= 1'h1;
		s_dn <= 1'h1;
		f_dn <= 1'h1;
		slope(1'h0, 16'h0000);
		s_dn <= 1'h0;
		slope(1'h0, 16'h000A);
		wr(8'h14, 32'h0000_4E20);
		slope(1'h0, 16'h0005);
		wr(8'h18, 32'h0000_3005);
		slope(1'h0, 16'hFFFB);
		s_up <= 1'h0;
		f_dn <= 1'h0;
		wr(8'h14, 32'h0000_0000);
	endtask
	task automatic t_pol();
		wr(8'h18, 32'h0000_1005);
		wr(8'h00, 32'h0000_0010);
		dn <= 1'h1;
		cyc(200);
		chk(mp, 16'h0000);
		wr(8'h00, 32'h0000_0000);
		slope(1'h0, 16'hFFF6);
		dn <= 1'h0;
	endtask
	task automatic t_ramp();
		up <= 1'h1;
		cyc(200);
		up <= 1'h0;
		wr(8'h00, 32'h0000_0001);
		slope(1'h1, 16'h000A);
		wr(8'h04, 32'h2710_0000);
		cyc(6);
		chk(ramp, mp);
		wr(8'h10, 32'h0064_0064);
		wr(8'h0C, 32'h2710_4E20);
		wr(8'h00, 32'h0000_0000);
		slope(1'h1, 16'hFFFB);
		cyc(800);
		chk(ramp, 16'h0000);
	endtask
	task automatic t_ce();
		ce_in <= 1'h0;
		up <= 1'h1;
		slope(1'h0, 16'h0000);
		up <= 1'h0;
		ce_in <= 1'h1;
	endtask
	task automatic t_keep();
		nv <= 16'sh0123;
		keep <= 1'h1;
		rst_in <= 1'h1;
		cyc(3);
		rst_in <= 1'h0;
		cyc(4);
		chk(mp, 16'h0123);
		keep <= 1'h0;
		rst_in <= 1'h1;
		cyc(3);
		rst_in <= 1'h0;
		cyc(4);
		chk(mp, 16'h0000);
	endtask
	initial
		forever #2.5 clk_in = ~clk_in;
	always @(posedge clk_in)
		tick_in <= ~tick_in;
	initial
	begin
		cyc(100000);
		failures++;
		end_of_test();
	end
	initial
	begin
		cyc(10);
		rst_in <= 1'h0;
		t_regs();
		t_mpot();
		t_src();
		t_pol();
		t_ramp();
		t_ce();
		t_keep();
		end_of_test();
	end
endmodule // rrm_ramp_bench
`default_nettype wire
